// File: hdl/rcc_pkg.sv
// Package for the two-channel retimer control block: states, settings carriers and counts.
// Assumes a single 25 MHz reference clock drives all digital control logic.
package rcc_pkg;

    localparam int unsigned REF_FREQ_MHZ = 25;
    localparam int unsigned BOOST_W = 5;
    localparam int unsigned SCORE_W = 8;
    localparam int unsigned TAPS = 5;
    localparam int unsigned TAP_W = 5;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned LOOK_DEPTH = 3;
    localparam int unsigned DWELL_CYCLES = 16;
    localparam int unsigned LOCK_WINDOW = 64;
    localparam int unsigned LOCK_TOL = 2;
    localparam logic [BOOST_W-1:0] BOOST_MAX = 5'h1F;
    localparam logic [8:0] PRBS9_SEED = 9'h1FF;
    localparam logic [30:0] PRBS31_SEED = 31'h7FFF_FFFF;
    localparam int unsigned PRBS9_TAP = 4;
    localparam int unsigned PRBS31_TAP = 27;
    localparam logic [1:0] SRC_RAW = 2'h0;
    localparam logic [1:0] SRC_RETIMED = 2'h1;
    localparam logic [1:0] SRC_PATTERN = 2'h2;
    localparam logic [1:0] SRC_LOOPBACK = 2'h3;

    typedef enum logic [2:0] {
        ADAPT_IDLE = 3'b000,
        ADAPT_WAIT_LOCK = 3'b001,
        ADAPT_MEASURE = 3'b010,
        ADAPT_DECIDE = 3'b011,
        ADAPT_DONE = 3'b100
    } rcc_adapt_state_t;

    typedef struct packed {
        logic [3:0] amplitude;
        logic [3:0] de_emphasis;
        logic edge_slow;
        logic invert;
        logic [1:0] source;
        logic pattern_long;
    } rcc_out_cfg_t;

    typedef struct packed {
        logic [WORD_W-1:0] data;
        logic [3:0] amplitude;
        logic [3:0] de_emphasis;
        logic edge_slow;
    } rcc_out_word_t;

endpackage

// File: hdl/rcc_skid_buffer.sv
// Two-entry buffer with valid/ready on both sides, carrying one output word and its driver settings.
// Assumes one clock and an asynchronous active-low reset; data leave from registers.
`timescale 1ns/100ps
module rcc_skid_buffer #(
    parameter int unsigned WIDTH = 25
) (
    input wire logic clock, // Reference clock.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic in_valid, // Source offers a word.
    output logic in_ready, // Buffer can take a word.
    input wire logic [WIDTH-1:0] in_data, // Word from source.
    output logic out_valid, // Word available.
    input wire logic out_ready, // Sink takes the word.
    output logic [WIDTH-1:0] out_data // Head word, registered.
);
    typedef struct packed {
        logic [WIDTH-1:0] head;
        logic [WIDTH-1:0] tail;
        logic [1:0] count;
    } rcc_buf_state_t;

    rcc_buf_state_t s_reg, s_next;

    initial begin
        if (WIDTH < 1) $error("WIDTH must be at least one");
    end

    always_comb begin
        logic push;
        logic pop;
        push = 1'b0;
        pop = 1'b0;
        s_next = s_reg;
        push = in_valid && (s_reg.count != 2'h2);
        pop = out_ready && (s_reg.count != 2'h0);
        case ({push, pop})
            2'b10: begin
                if (s_reg.count == 2'h0) begin
                    s_next.head = in_data;
                end else begin
                    s_next.tail = in_data;
                end
                s_next.count = s_reg.count + 2'h1;
            end
            2'b01: begin
                s_next.head = s_reg.tail;
                s_next.count = s_reg.count - 2'h1;
            end
            2'b11: begin
                // A word passing through a one-entry buffer replaces the head directly.
                if (s_reg.count == 2'h1) begin
                    s_next.head = in_data;
                end else begin
                    s_next.head = s_reg.tail;
                    s_next.tail = in_data;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign in_ready = (s_reg.count != 2'h2);
    assign out_valid = (s_reg.count != 2'h0);
    assign out_data = s_reg.head;
endmodule

// File: hdl/rcc_channel_control.sv
// Per-channel control for a two-lane retimer: boost adaptation, lock check, pattern generator, output mux.
// Assumes the reference clock drives clock, lane inputs are already sampled, and words move 16 bits a cycle.
`timescale 1ns/100ps
// Summary of operation
// - Two channels are built from one generate loop and share no state with each other.
// - Adaptation starts once signal is detected and begins right after the clock recovery loop locks.
// - A reset of the clock recovery loop restarts adaptation.
// - Adaptation steps the linear equalizer boost up to maximise the eye-based quality score.
// - If the score does not improve within the look-ahead depth, boost settles at the last better setting.
// - Five decision feedback taps adapt weight and polarity together with the linear equalizer setting.
// - Lock is judged by counting recovered-clock ticks against the 25 MHz reference.
// - The expected oscillator count is preloaded per data rate so loss of lock is flagged within one window.
// - Each channel generates a selectable 9-bit or 31-bit pseudo-random sequence.
// - The output mux picks raw, retimed, generated pattern or loopback from the other channel.
// - Amplitude, de-emphasis, edge rate and polarity inversion are applied to the selected stream.
module rcc_channel_control #(
    parameter int unsigned LANES = 2,
    parameter int unsigned LOOK_DEPTH = rcc_pkg::LOOK_DEPTH,
    parameter int unsigned DWELL = rcc_pkg::DWELL_CYCLES
) (
    input wire logic clock, // 25 MHz reference clock.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic [LANES-1:0] signal_detect, // Input signal present.
    input wire logic [LANES-1:0] recovery_reset, // Clock recovery loop reset, level.
    input wire logic [LANES-1:0] rate_tick, // Divided recovered-clock tick, sampled.
    input wire logic [LANES*8-1:0] rate_expect, // Preloaded expected ticks per window.
    input wire logic [LANES*rcc_pkg::SCORE_W-1:0] quality_score, // Eye monitor score.
    input wire logic [LANES*rcc_pkg::TAPS-1:0] dfe_error_sign, // Per-tap error correlation sign.
    input wire logic [LANES*rcc_pkg::WORD_W-1:0] raw_data, // Equalized data, not retimed.
    input wire logic [LANES*rcc_pkg::WORD_W-1:0] retimed_data, // Retimed data.
    input wire rcc_pkg::rcc_out_cfg_t [LANES-1:0] out_cfg, // Host output settings.
    input wire logic [LANES-1:0] out_ready, // Serializer takes the word.
    output logic [LANES-1:0] out_valid, // Word available for serializer.
    output rcc_pkg::rcc_out_word_t [LANES-1:0] out_word, // Word with driver settings.
    output logic [LANES-1:0] recovery_locked, // Lock indicator.
    output logic [LANES-1:0] adapt_done, // Adaptation finished.
    output logic [LANES*rcc_pkg::BOOST_W-1:0] linear_equalizer_boost, // Boost setting.
    output logic [LANES*rcc_pkg::TAPS*rcc_pkg::TAP_W-1:0] decision_feedback_equalizer_taps // Signed taps.
);
    localparam int unsigned SW = rcc_pkg::SCORE_W;
    localparam int unsigned BW = rcc_pkg::BOOST_W;
    localparam int unsigned WW = rcc_pkg::WORD_W;
    localparam int unsigned TW = rcc_pkg::TAP_W;
    localparam int unsigned NT = rcc_pkg::TAPS;
    localparam int unsigned OW = $bits(rcc_pkg::rcc_out_word_t);

    initial begin
        if (LANES != 2) $error("loopback needs exactly two lanes");
        if (LOOK_DEPTH < 1 || LOOK_DEPTH > 15) $error("LOOK_DEPTH must be 1 to 15");
        if (DWELL < 1 || DWELL > 255) $error("DWELL must be 1 to 255");
    end

    // One step of a Fibonacci generator producing a word, newest bit in the LSB.
    function automatic logic [30:0] prbs_step(input logic [30:0] st, input logic long_seq);
        logic [30:0] s;
        logic fb;
        s = st;
        fb = 1'b0;
        // Both lengths shift the whole register, so the low bits always hold the last word of sequence bits.
        for (int i = 0; i < WW; i++) begin
            fb = long_seq ? (s[30] ^ s[rcc_pkg::PRBS31_TAP]) : (s[8] ^ s[rcc_pkg::PRBS9_TAP]);
            s = {s[29:0], fb};
        end
        return s;
    endfunction

    typedef struct packed {
        rcc_pkg::rcc_adapt_state_t state;
        logic [BW-1:0] boost;
        logic [BW-1:0] best_boost;
        logic [SW-1:0] best_score;
        logic [3:0] look;
        logic [7:0] dwell;
        logic [NT*TW-1:0] taps;
        logic [7:0] win;
        logic [7:0] ticks;
        logic locked;
        logic [30:0] prbs;
        logic [1:0] src_last;
        logic long_last;
    } rcc_lane_state_t;

    logic [LANES-1:0] buf_ready;

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : lane
            rcc_lane_state_t s_reg, s_next;
            logic [WW-1:0] pattern_word;
            logic [WW-1:0] sel;
            logic [30:0] prbs_base;
            logic [30:0] prbs_stepped;
            rcc_pkg::rcc_out_word_t offer;

            // A fresh selection starts from the seed in the same cycle, so no stale word reaches the buffer.
            assign prbs_base = (s_reg.src_last != rcc_pkg::SRC_PATTERN
                || s_reg.long_last != out_cfg[g].pattern_long)
                ? (out_cfg[g].pattern_long ? rcc_pkg::PRBS31_SEED : {22'h00_0000, rcc_pkg::PRBS9_SEED})
                : s_reg.prbs;
            assign prbs_stepped = prbs_step(prbs_base, out_cfg[g].pattern_long);
            assign pattern_word = prbs_stepped[WW-1:0];

            always_comb begin
                logic [7:0] diff;
                logic [TW-1:0] tap;
                diff = 8'h00;
                tap = '0;
                s_next = s_reg;
                // Lock window: count ticks over the first LOCK_WINDOW-1 of every LOCK_WINDOW reference cycles, compare to preload.
                s_next.win = s_reg.win + 8'h01;
                if (rate_tick[g]) begin
                    s_next.ticks = s_reg.ticks + 8'h01;
                end
                if (s_reg.win == 8'(rcc_pkg::LOCK_WINDOW - 1)) begin
                    diff = (s_reg.ticks > rate_expect[g*8 +: 8]) ? s_reg.ticks - rate_expect[g*8 +: 8]
                        : rate_expect[g*8 +: 8] - s_reg.ticks;
                    s_next.locked = (diff <= 8'(rcc_pkg::LOCK_TOL));
                    s_next.win = 8'h00;
                    s_next.ticks = 8'h00;
                end
                case (s_reg.state)
                    rcc_pkg::ADAPT_IDLE: begin
                        if (signal_detect[g]) begin
                            s_next.state = rcc_pkg::ADAPT_WAIT_LOCK;
                        end
                    end
                    rcc_pkg::ADAPT_WAIT_LOCK: begin
                        if (s_reg.locked) begin
                            s_next.state = rcc_pkg::ADAPT_MEASURE;
                            s_next.boost = '0;
                            s_next.best_boost = '0;
                            s_next.best_score = '0;
                            s_next.look = 4'h0;
                            s_next.dwell = 8'(DWELL);
                        end
                    end
                    rcc_pkg::ADAPT_MEASURE: begin
                        s_next.dwell = s_reg.dwell - 8'h01;
                        // Taps follow the error sign while the current boost settles.
                        for (int t = 0; t < NT; t++) begin
                            tap = s_reg.taps[t*TW +: TW];
                            if (dfe_error_sign[g*NT + t] && tap != 5'h0F) begin
                                tap = tap + 5'h01;
                            end else if (!dfe_error_sign[g*NT + t] && tap != 5'h10) begin
                                tap = tap - 5'h01;
                            end
                            s_next.taps[t*TW +: TW] = tap;
                        end
                        if (s_reg.dwell == 8'h01) begin
                            s_next.state = rcc_pkg::ADAPT_DECIDE;
                        end
                    end
                    rcc_pkg::ADAPT_DECIDE: begin
                        if (quality_score[g*SW +: SW] > s_reg.best_score) begin
                            s_next.best_score = quality_score[g*SW +: SW];
                            s_next.best_boost = s_reg.boost;
                            s_next.look = 4'h0;
                        end else begin
                            s_next.look = s_reg.look + 4'h1;
                        end
                        if ((quality_score[g*SW +: SW] <= s_reg.best_score && s_reg.look + 4'h1 >= 4'(LOOK_DEPTH))
                            || s_reg.boost == rcc_pkg::BOOST_MAX) begin
                            s_next.boost = (quality_score[g*SW +: SW] > s_reg.best_score) ? s_reg.boost
                                : s_reg.best_boost;
                            s_next.state = rcc_pkg::ADAPT_DONE;
                        end else begin
                            s_next.boost = s_reg.boost + 5'h01;
                            s_next.dwell = 8'(DWELL);
                            s_next.state = rcc_pkg::ADAPT_MEASURE;
                        end
                    end
                    rcc_pkg::ADAPT_DONE: begin
                        if (!signal_detect[g]) begin
                            s_next.state = rcc_pkg::ADAPT_IDLE;
                        end
                    end
                    default: s_next.state = rcc_pkg::ADAPT_IDLE;
                endcase
                // Recovery reset drops lock and forces a fresh adaptation.
                if (recovery_reset[g]) begin
                    s_next.state = rcc_pkg::ADAPT_IDLE;
                    s_next.locked = 1'b0;
                    s_next.win = 8'h00;
                    s_next.ticks = 8'h00;
                end
                // Pattern generator advances only when its word is accepted, so no bits are skipped.
                s_next.src_last = out_cfg[g].source;
                s_next.long_last = out_cfg[g].pattern_long;
                if (out_cfg[g].source == rcc_pkg::SRC_PATTERN) begin
                    s_next.prbs = buf_ready[g] ? prbs_stepped : prbs_base;
                end
            end

            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    s_reg <= '{state: rcc_pkg::ADAPT_IDLE, prbs: rcc_pkg::PRBS31_SEED, default: '0};
                end else begin
                    s_reg <= s_next;
                end
            end

            always_comb begin
                case (out_cfg[g].source)
                    rcc_pkg::SRC_RAW: sel = raw_data[g*WW +: WW];
                    rcc_pkg::SRC_RETIMED: sel = retimed_data[g*WW +: WW];
                    rcc_pkg::SRC_PATTERN: sel = pattern_word;
                    rcc_pkg::SRC_LOOPBACK: sel = retimed_data[(LANES-1-g)*WW +: WW];
                    default: sel = retimed_data[g*WW +: WW];
                endcase
                offer.data = out_cfg[g].invert ? ~sel : sel;
                offer.amplitude = out_cfg[g].amplitude;
                offer.de_emphasis = out_cfg[g].de_emphasis;
                offer.edge_slow = out_cfg[g].edge_slow;
            end

            rcc_skid_buffer #(
                .WIDTH(OW)
            ) u_buf (
                .clock(clock),
                .reset_n(reset_n),
                .in_valid(1'b1),
                .in_ready(buf_ready[g]),
                .in_data(offer),
                .out_valid(out_valid[g]),
                .out_ready(out_ready[g]),
                .out_data(out_word[g])
            );

            assign recovery_locked[g] = s_reg.locked;
            assign adapt_done[g] = (s_reg.state == rcc_pkg::ADAPT_DONE);
            assign linear_equalizer_boost[g*BW +: BW] = s_reg.boost;
            assign decision_feedback_equalizer_taps[g*NT*TW +: NT*TW] = s_reg.taps;
        end
    endgenerate
endmodule

// File: verification/rcc_channel_control_chk.sv
// Concurrent checks on the retimer channel control ports, lane 0 mostly, lane 1 for restart and independence.
// Assumes a bench that runs the design with DWELL of at least 2.
`timescale 1ns/100ps
module rcc_channel_control_chk #(
    parameter int unsigned LANES = 2,
    parameter int unsigned DWELL = 2
) (
    input wire logic clock, // Reference clock.
    input wire logic reset_n, // Reset, active low.
    input wire logic [LANES-1:0] signal_detect, // Signal present.
    input wire logic [LANES-1:0] recovery_reset, // Loop reset.
    input wire rcc_pkg::rcc_out_cfg_t [LANES-1:0] out_cfg, // Host settings.
    input wire logic [LANES-1:0] out_ready, // Sink ready.
    input wire logic [LANES-1:0] out_valid, // Word offered.
    input wire rcc_pkg::rcc_out_word_t [LANES-1:0] out_word, // Offered word.
    input wire logic [LANES-1:0] recovery_locked, // Lock flag.
    input wire logic [LANES-1:0] adapt_done, // Adaptation over.
    input wire logic [LANES*rcc_pkg::BOOST_W-1:0] linear_equalizer_boost, // Boost.
    input wire logic [LANES*rcc_pkg::TAPS*rcc_pkg::TAP_W-1:0] decision_feedback_equalizer_taps // Taps.
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic [4:0] b0;
    assign b0 = linear_equalizer_boost[4:0];
    hold_word_a: assert property (out_valid[0] && !out_ready[0] |=> out_valid[0] && $stable(out_word[0]))
        else $error("Output word moved while the sink stalled.");
    cfg_follow_a: assert property ((out_ready[0] && $stable(out_cfg[0])) [*4] ##0 out_valid[0] |->
        {out_word[0].amplitude, out_word[0].de_emphasis, out_word[0].edge_slow} ==
        {out_cfg[0].amplitude, out_cfg[0].de_emphasis, out_cfg[0].edge_slow}) else $error("Driver settings lost.");
    restart_clears_a: assert property (recovery_reset[1] |=> !adapt_done[1] && !recovery_locked[1])
        else $error("Loop reset did not restart adaptation.");
    signal_gone_a: assert property (!signal_detect[0] [*2] |-> !adapt_done[0])
        else $error("Adaptation done without signal.");
    boost_step_a: assert property ($changed(b0) |-> adapt_done[0] || b0 == $past(b0) + 5'h1 || b0 == 5'h0)
        else $error("Boost jumped by more than one step.");
    // A step lasts DWELL measure cycles plus one decide cycle, so two idle cycles is the floor.
    boost_dwell_a: assert property ($changed(b0) && !adapt_done[0] && b0 != 5'h0 |=> $stable(b0) [*2])
        else $error("Boost stepped without dwelling.");
    settle_lower_a: assert property ($rose(adapt_done[0]) |-> b0 <= $past(b0))
        else $error("Boost settled above the last step.");
    taps_frozen_a: assert property (adapt_done[0] && $past(adapt_done[0]) |->
        $stable(decision_feedback_equalizer_taps[24:0])) else $error("Taps moved after adaptation.");
    lock_window_a: assert property ($changed(recovery_locked[0]) && !recovery_reset[0]
        && !$past(recovery_reset[0]) |=> $stable(recovery_locked[0]) [*8])
        else $error("Lock flag changed inside a window.");
    lanes_apart_a: assert property (recovery_reset[1] && !recovery_reset[0] && signal_detect[0] && adapt_done[0]
        |=> adapt_done[0]) else $error("Lane 1 reset disturbed lane 0.");
    cover property ($rose(adapt_done[0]));
    cover property (out_valid[0] && !out_ready[0]);
    cover property ($fell(recovery_locked[0]));
endmodule
bind rcc_channel_control rcc_channel_control_chk #(.LANES(LANES), .DWELL(DWELL)) u_chk (.clock(clock),
    .reset_n(reset_n), .signal_detect(signal_detect), .recovery_reset(recovery_reset), .out_cfg(out_cfg),
    .out_ready(out_ready), .out_valid(out_valid), .out_word(out_word), .recovery_locked(recovery_locked),
    .adapt_done(adapt_done), .linear_equalizer_boost(linear_equalizer_boost),
    .decision_feedback_equalizer_taps(decision_feedback_equalizer_taps));

// File: verification/rcc_far_side.sv
// Far-side model: recovered-clock tick source for both lanes and a serializer sink that may stall.
// Assumes it is clocked by the reference; it records every lane 0 word it takes.
`timescale 1ns/100ps
module rcc_far_side (
    input wire logic clock, // Reference clock.
    input wire logic stall, // Sink throttles when high.
    input wire logic out_valid, // Lane 0 word offered.
    input wire rcc_pkg::rcc_out_word_t out_word, // Lane 0 word.
    output logic [1:0] out_ready, // Sink takes words.
    output logic [1:0] rate_tick // Lane 0 ticks every cycle, lane 1 every other.
);
    rcc_pkg::rcc_out_word_t got[$];
    logic [2:0] phase = 3'h0;
    initial begin
        out_ready = 2'b11;
        rate_tick = 2'b01;
    end
    always @(negedge clock) begin
        phase <= phase + 3'h1;
        rate_tick <= {~rate_tick[1], 1'b1};
        out_ready <= stall ? {2{phase == 3'h4}} : 2'b11;
    end
    always @(posedge clock) if (out_valid && out_ready[0]) got.push_back(out_word);
endmodule

// File: verification/tb_rcc_channel_control.sv
// Self-checking bench: lock, adaptation, restart, output sources, settings and both patterns.
// Assumes the far-side model supplies ticks and takes words; inputs change on the falling edge.
`timescale 1ns/100ps
module tb_rcc_channel_control;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] signal_detect = 2'b11, recovery_reset = 2'b00, out_ready, rate_tick, out_valid, recovery_locked;
    logic [1:0] adapt_done;
    logic stall = 1'b1;
    logic [15:0] rate_expect = 16'h2040, quality_score = 16'h0000;
    logic [9:0] dfe_error_sign = 10'h015, boost;
    logic [31:0] raw_data = 32'hC001_1234, retimed_data = 32'hBEEF_5A3C;
    logic [15:0] srcv[4] = '{16'h1234, 16'h5A3C, 16'h0000, 16'hBEEF};
    logic [4:0] d;
    logic [30:0] st;
    rcc_pkg::rcc_out_cfg_t [1:0] out_cfg = '0;
    rcc_pkg::rcc_out_word_t [1:0] out_word;
    rcc_pkg::rcc_out_word_t w;
    int n_mismatch = 0, comparisons = 0;
    always #20 clock = ~clock;
    rcc_channel_control #(.DWELL(2)) u_rcc_channel_control (.clock(clock), .reset_n(reset_n),
        .signal_detect(signal_detect), .recovery_reset(recovery_reset), .rate_tick(rate_tick),
        .rate_expect(rate_expect), .quality_score(quality_score), .dfe_error_sign(dfe_error_sign),
        .raw_data(raw_data), .retimed_data(retimed_data), .out_cfg(out_cfg), .out_ready(out_ready),
        .out_valid(out_valid), .out_word(out_word), .recovery_locked(recovery_locked), .adapt_done(adapt_done),
        .linear_equalizer_boost(boost), .decision_feedback_equalizer_taps());
    rcc_far_side u_rcc_far_side (.clock(clock), .stall(stall), .out_valid(out_valid[0]), .out_word(out_word[0]),
        .out_ready(out_ready), .rate_tick(rate_tick));
    // Lane 0 eye peaks at boost 5; lane 1 keeps improving up to the top of the range.
    // Lane 0's score dips past boost 5, so its search gives up after the look-ahead depth and settles back at boost 5.
    always @(negedge clock) begin
        d = (boost[4:0] > 5'h05) ? boost[4:0] - 5'h05 : 5'h05 - boost[4:0];
        quality_score <= {8'h10 + {3'h0, boost[9:5]}, 8'hF0 - {d, 3'h0}};
        dfe_error_sign <= ~dfe_error_sign;
    end
    task automatic end_sim();
        if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Bit 1 of sel picks adapt_done over recovery_locked, bit 0 the lane.
    task automatic wait_for(input logic [1:0] sel, input logic val);
        for (int i = 0; i < 700; i++) begin
            @(negedge clock);
            if ((sel[1] ? adapt_done[sel[0]] : recovery_locked[sel[0]]) === val) return;
        end
        n_mismatch++;
        end_sim();
    endtask
    task automatic read_word(output rcc_pkg::rcc_out_word_t r);
        for (int i = 0; i < 100; i++) begin
            if (u_rcc_far_side.got.size() > 0) begin
                r = u_rcc_far_side.got.pop_front();
                return;
            end
            @(negedge clock);
        end
        n_mismatch++;
        end_sim();
    endtask
    function automatic logic [15:0] prbs_word(input logic len, inout logic [30:0] s);
        logic nb;
        prbs_word = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            nb = len ? s[30] ^ s[27] : s[8] ^ s[4];
            s = {s[29:0], nb};
            prbs_word = {prbs_word[14:0], nb};
        end
    endfunction
    initial begin
        repeat (3) @(negedge clock);
        check({out_valid, recovery_locked, adapt_done, boost}, 32'h0000_0000);
        reset_n = 1'b1;
        wait_for(2'b00, 1'b1);
        wait_for(2'b01, 1'b1);
        wait_for(2'b10, 1'b1);
        wait_for(2'b11, 1'b1);
        check(boost, {5'h1F, 5'h05});
        rate_expect[7:0] = 8'h30;
        wait_for(2'b00, 1'b0);
        rate_expect[7:0] = 8'h40;
        wait_for(2'b00, 1'b1);
        recovery_reset[1] = 1'b1;
        @(negedge clock);
        check({recovery_locked[1], adapt_done[1]}, 32'h0000_0000);
        recovery_reset[1] = 1'b0;
        wait_for(2'b11, 1'b1);
        check({adapt_done, boost}, {2'b11, 5'h1F, 5'h05});
        signal_detect[0] = 1'b0;
        repeat (3) @(negedge clock);
        check(adapt_done, 32'h0000_0002);
        signal_detect[0] = 1'b1;
        wait_for(2'b10, 1'b1);
        check(boost[4:0], 5'h05);
        for (int s = 0; s < 4; s++) begin
            if (s == 2) continue;
            out_cfg[0] = '{4'h3 + s[3:0], 4'hC - s[3:0], s[0], s[1], s[1:0], 1'b0};
            // Two stalled pops are needed before the buffer holds only words with the new settings.
            repeat (20) @(negedge clock);
            u_rcc_far_side.got.delete();
            read_word(w);
            check(w.data, srcv[s] ^ {16{s[1]}});
            check({w.amplitude, w.de_emphasis, w.edge_slow}, {4'h3 + s[3:0], 4'hC - s[3:0], s[0]});
        end
        for (int len = 0; len < 2; len++) begin
            out_cfg[0] = '{4'h5, 4'h2, 1'b0, 1'b0, rcc_pkg::SRC_RETIMED, 1'b0};
            repeat (20) @(negedge clock);
            out_cfg[0] = '{4'h5, 4'h2, 1'b0, 1'b0, rcc_pkg::SRC_PATTERN, len[0]};
            u_rcc_far_side.got.delete();
            st = len[0] ? rcc_pkg::PRBS31_SEED : {22'h0, rcc_pkg::PRBS9_SEED};
            read_word(w);
            for (int k = 0; k < 4 && w.data === 16'h5A3C; k++) read_word(w);
            for (int k = 0; k < 4; k++) begin
                check(w.data, prbs_word(len[0], st));
                read_word(w);
            end
        end
        stall = 1'b0;
        repeat (8) @(negedge clock);
        read_word(w);
        check(w.amplitude, 4'h5);
        end_sim();
    end
endmodule
